// [hdl/tmf_pkg.sv]
// constants shared by the temperature monitor and fault output logic
// assumes one 125 MHz clock domain, register writes arrive as one-cycle strobes
// Overview of operation
// - compare temperatures after each complete scan
// - temperature compare uses full 10 bits
// - signed temperature code, half degree steps
// - diode fault reports all-zero temperature code
// - detect diode open/short, configurable as fault
// - offset times four added to result
// - 3-bit signed offsets at given fields
// - 6-bit gain trims, one bit inverted
// - 2-bit field selects threshold and gain
// - fault enable bits per sensor, current, alert
// - internal threshold low bits in offset register
// - voltage limits use upper eight bits
// - results readable on both ports, used internally
// - outputs unlatched except configurable overcurrent and diode-caused overtemp
// - flags latch, cleared one bit per write
// - two general fault outputs identical, programmable
// - overtemp output on thresholds and/or diodes
// - diode-caused overtemp holds until flags cleared
// - alert asserts when any fault output asserts
package tmf_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RES_W = 10;

  // register offsets
  localparam logic [7:0] OFS_RES_LAST = 8'h16;
  localparam logic [7:0] OFS_CUR_TH_GAIN = 8'h19;
  localparam logic [7:0] OFS_FLT_EN = 8'h1B;
  localparam logic [7:0] OFS_FA_DEP = 8'h1D;
  localparam logic [7:0] OFS_FB_DEP = 8'h1E;
  localparam logic [7:0] OFS_OT_DEP = 8'h1F;
  localparam logic [7:0] OFS_VOLT_OV = 8'h30;
  localparam logic [7:0] OFS_VOLT_UV = 8'h31;
  localparam logic [7:0] OFS_TH_BASE = 8'h46;
  localparam logic [7:0] OFS_TH_LAST = 8'h4B;
  localparam logic [7:0] OFS_INT_LOW = 8'h4D;
  localparam logic [7:0] OFS_R2_GAIN = 8'h4F;
  localparam logic [7:0] OFS_FLAGS = 8'h53;
  localparam logic [7:0] OFS_SEC_FLAGS = 8'h54;
  localparam logic [7:0] OFS_OC_CFG = 8'h5C;

  // fault enable, offset, threshold low bit, gain trim and latch fields
  localparam int FE_INT = 0;
  localparam int FE_R1 = 1;
  localparam int FE_R2 = 2;
  localparam int FE_CS = 3;
  localparam int FE_ALERT = 4;
  localparam int TRIM1_LSB = 5;
  localparam int TRIM2_LSB = 4;
  localparam int INT_PRI_LSB = 0;
  localparam int INT_SEC_LSB = 2;
  localparam int GAIN1_LSB = 2;
  localparam int GAIN1_INV = 6;
  localparam int OC_LATCH_BIT = 2;

  // flag register fields (bits 0..2 are the three temperature sensors)
  localparam int FL_DIODE1 = 3;
  localparam int FL_DIODE2 = 4;
  localparam int FL_OV = 5;
  localparam int FL_OC = 6;
  localparam int FL_UV = 7;

  // output dependency fields
  localparam int DEP_UV = 0;
  localparam int DEP_OV = 1;
  localparam int DEP_OT = 2;
  localparam int DEP_OC = 3;
  localparam int OTD_PRI = 0;
  localparam int OTD_DIODE = 1;

  // adc channel numbering, equal to result register offset / 2
  localparam int NUM_VOLT = 8;
  localparam int NUM_TEMP = 3;
  localparam int NUM_CH = 12;
  localparam logic [3:0] CH_INT = 4'h8;
  localparam logic [3:0] CH_CUR = 4'hB;

  // values after reset
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TH = 8'h7F;
  localparam logic [7:0] RST_OV = 8'hFF;
  localparam logic [7:0] RST_OT_DEP = 8'h03;
  localparam logic [9:0] DIODE_FAULT_CODE = 10'h000;

  // primary overcurrent threshold in mV and sense gain in V/V
  localparam logic [7:0] OC_MV_0 = 8'hC8;
  localparam logic [7:0] OC_MV_1 = 8'h64;
  localparam logic [7:0] OC_MV_2 = 8'h32;
  localparam logic [7:0] OC_MV_3 = 8'h19;
  localparam logic [5:0] CS_GAIN_0 = 6'h06;
  localparam logic [5:0] CS_GAIN_1 = 6'h0C;
  localparam logic [5:0] CS_GAIN_2 = 6'h18;
  localparam logic [5:0] CS_GAIN_3 = 6'h30;

endpackage

// [hdl/tmf_result_mem.sv]
// conversion result store with one write port and two registered read ports
// assumes the writer and both readers share one clock
module tmf_result_mem
  import tmf_pkg::*;
#(
  parameter int DEPTH = 12,
  parameter int WIDTH = 10,
  parameter int AW = 4
)
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_a_i,
  output logic [WIDTH-1:0] rd_data_a_o,
  input wire logic [AW-1:0] rd_addr_b_i,
  output logic [WIDTH-1:0] rd_data_b_o
);

  logic [WIDTH-1:0] mem_reg [DEPTH]; // one word per channel

  ////////////////////////////////////////////////////////////////////////////
  // storage; out of range writes are dropped so no phantom word appears
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_reg[i] <= '0;
      end
    end
    else if (wr_en_i && (int'(wr_addr_i) < DEPTH))
    begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered reads; out of range reads give zero
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_data_a_o <= '0;
      rd_data_b_o <= '0;
    end
    else
    begin
      rd_data_a_o <= (int'(rd_addr_a_i) < DEPTH) ? mem_reg[rd_addr_a_i] : '0;
      rd_data_b_o <= (int'(rd_addr_b_i) < DEPTH) ? mem_reg[rd_addr_b_i] : '0;
    end
  end

endmodule

// [hdl/tmf_temp_monitor.sv]
// temperature monitor and fault output logic of the system monitor
// assumes adc results, scan end and comparator levels come from the analog front end;
// the serial and test-port decoders present one-cycle register strobes on this clock
module tmf_temp_monitor
  import tmf_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  // register access from the two-wire management decoder
  input wire logic [7:0] smb_addr_i,
  input wire logic smb_wr_i,
  input wire logic smb_rd_i,
  input wire logic [7:0] smb_wdata_i,
  output logic [7:0] smb_rdata_o,
  output logic smb_rvalid_o,
  // register access from the test-port decoder
  input wire logic [7:0] jtag_addr_i,
  input wire logic jtag_wr_i,
  input wire logic jtag_rd_i,
  input wire logic [7:0] jtag_wdata_i,
  output logic [7:0] jtag_rdata_o,
  output logic jtag_rvalid_o,
  // conversion stream
  input wire logic adc_valid_i,
  input wire logic [3:0] adc_chan_i,
  input wire logic [9:0] adc_data_i,
  input wire logic scan_done_i,
  // asynchronous analog levels
  input wire logic [1:0] diode_open_i,
  input wire logic [1:0] diode_short_i,
  input wire logic oc_comp_i,
  input wire logic [1:0] gpio_fault_i,
  // fault pins, active low
  output logic general_fault_out_a_n_o,
  output logic general_fault_out_b_n_o,
  output logic overtemp_out_n_o,
  output logic overcurrent_out_n_o,
  output logic alert_n_o,
  // analog settings
  output logic [7:0] oc_thresh_mv_o,
  output logic [5:0] cs_gain_o,
  output logic [5:0] remote1_gain_trim_o,
  output logic [5:0] remote2_gain_trim_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] cur_th_gain_reg; // threshold select and sensor 1 gain trim
  logic [7:0] flt_en_reg; // fault and alert enables, sensor 1 offset
  logic [7:0] fa_dep_reg; // general output a dependencies
  logic [7:0] fb_dep_reg; // general output b dependencies
  logic [7:0] ot_dep_reg; // overtemp output dependencies
  logic [7:0] ov_lim_reg; // voltage upper limit, 8 bits
  logic [7:0] uv_lim_reg; // voltage lower limit, 8 bits
  logic [7:0] th_reg [6]; // primary/secondary threshold high bytes
  logic [6:0] int_low_reg; // internal low threshold bits, sensor 2 offset
  logic [5:0] r2_gain_reg; // sensor 2 gain trim
  logic [7:0] flags_reg; // sticky fault flags
  logic [2:0] sec_flags_reg; // sticky secondary temperature flags
  logic [7:0] oc_cfg_reg; // overcurrent latch configuration
  logic signed [9:0] temp_reg [NUM_TEMP]; // latest temperatures, remote ones trimmed
  logic [NUM_VOLT-1:0] ov_pend_reg; // voltage over this scan
  logic [NUM_VOLT-1:0] uv_pend_reg; // voltage under this scan
  logic [2:0] pri_now_reg; // primary violations of last scan
  logic [2:0] sec_now_reg; // secondary violations of last scan
  logic ov_now_reg; // any voltage over in last scan
  logic uv_now_reg; // any voltage under in last scan
  logic [4:0] sync1_reg; // first synchroniser stage
  logic [4:0] sync2_reg; // second synchroniser stage
  logic [1:0] diode_bad; // synchronised open or short per remote diode
  logic oc_sync; // synchronised overcurrent comparator
  logic wr_en; // any write strobe
  logic [7:0] wr_addr; // winning write address
  logic [7:0] wr_data; // winning write data
  logic [9:0] adc_word; // value stored for this conversion
  logic [9:0] th_pri [NUM_TEMP]; // full primary thresholds
  logic [9:0] th_sec [NUM_TEMP]; // full secondary thresholds
  logic [2:0] pri_hit; // primary compare this scan
  logic [2:0] sec_hit; // secondary compare this scan
  logic [7:0] flag_set; // flag events this cycle
  logic [7:0] flag_clr; // one-bit clear from a write
  logic oc_now; // current overcurrent condition
  logic [9:0] mem_a; // result word for the serial port read
  logic [9:0] mem_b; // result word for the test port read
  logic [7:0] smb_cfg_reg; // register byte captured at read
  logic [7:0] jtag_cfg_reg;
  logic smb_res_reg; // read targets a result register
  logic jtag_res_reg;
  logic smb_lsb_reg; // read targets the low bits of a result
  logic jtag_lsb_reg;
  logic smb_rd_reg; // read in flight
  logic jtag_rd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // functions
  // sign-extended offset code times four; 2 degree steps, -8 to +6 degrees
  function automatic logic [9:0] trim_ofs(input logic [2:0] code);
    trim_ofs = {{5{code[2]}}, code, 2'b00};
  endfunction

  // general fault output decode, shared by both outputs
  function automatic logic gen_fault(input logic [7:0] dep, input logic uv, input logic ov,
                                     input logic ot, input logic oc);
    gen_fault = (dep[DEP_UV] & uv) | (dep[DEP_OV] & ov) | (dep[DEP_OT] & ot) | (dep[DEP_OC] & oc);
  endfunction

  // configuration byte read decode, shared by both ports
  function automatic logic [7:0] cfg_read(input logic [7:0] a);
    logic [7:0] v;
    v = RST_ZERO;
    if (a == OFS_CUR_TH_GAIN) v = cur_th_gain_reg;
    else if (a == OFS_FLT_EN) v = flt_en_reg;
    else if (a == OFS_FA_DEP) v = fa_dep_reg;
    else if (a == OFS_FB_DEP) v = fb_dep_reg;
    else if (a == OFS_OT_DEP) v = ot_dep_reg;
    else if (a == OFS_VOLT_OV) v = ov_lim_reg;
    else if (a == OFS_VOLT_UV) v = uv_lim_reg;
    else if (a >= OFS_TH_BASE && a <= OFS_TH_LAST) v = th_reg[3'(a - OFS_TH_BASE)];
    else if (a == OFS_INT_LOW) v = {1'b0, int_low_reg};
    else if (a == OFS_R2_GAIN) v = {2'b00, r2_gain_reg};
    else if (a == OFS_FLAGS) v = flags_reg;
    else if (a == OFS_SEC_FLAGS) v = {5'h00, sec_flags_reg};
    else if (a == OFS_OC_CFG) v = oc_cfg_reg;
    cfg_read = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // synchronise analog levels; only the second stage is read
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end
    else
    begin
      sync1_reg <= {oc_comp_i, diode_short_i, diode_open_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign diode_bad = sync2_reg[1:0] | sync2_reg[3:2];
  assign oc_sync = sync2_reg[4];

  ////////////////////////////////////////////////////////////////////////////
  // write arbitration: the serial port wins a same-cycle collision
  assign wr_en = smb_wr_i | jtag_wr_i;
  assign wr_addr = smb_wr_i ? smb_addr_i : jtag_addr_i;
  assign wr_data = smb_wr_i ? smb_wdata_i : jtag_wdata_i;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cur_th_gain_reg <= RST_ZERO;
      flt_en_reg <= RST_ZERO;
      fa_dep_reg <= RST_ZERO;
      fb_dep_reg <= RST_ZERO;
      ot_dep_reg <= RST_OT_DEP;
      ov_lim_reg <= RST_OV;
      uv_lim_reg <= RST_ZERO;
      int_low_reg <= 7'h00;
      r2_gain_reg <= 6'h00;
      oc_cfg_reg <= RST_ZERO;
      for (int i = 0; i < 6; i++)
      begin
        th_reg[i] <= RST_TH;
      end
    end
    else if (wr_en)
    begin
      if (wr_addr == OFS_CUR_TH_GAIN) cur_th_gain_reg <= wr_data;
      else if (wr_addr == OFS_FLT_EN) flt_en_reg <= wr_data;
      else if (wr_addr == OFS_FA_DEP) fa_dep_reg <= wr_data;
      else if (wr_addr == OFS_FB_DEP) fb_dep_reg <= wr_data;
      else if (wr_addr == OFS_OT_DEP) ot_dep_reg <= wr_data;
      else if (wr_addr == OFS_VOLT_OV) ov_lim_reg <= wr_data;
      else if (wr_addr == OFS_VOLT_UV) uv_lim_reg <= wr_data;
      else if (wr_addr >= OFS_TH_BASE && wr_addr <= OFS_TH_LAST) th_reg[3'(wr_addr - OFS_TH_BASE)] <= wr_data;
      else if (wr_addr == OFS_INT_LOW) int_low_reg <= wr_data[6:0];
      else if (wr_addr == OFS_R2_GAIN) r2_gain_reg <= wr_data[5:0];
      else if (wr_addr == OFS_OC_CFG) oc_cfg_reg <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion intake: trim remote results, zero code on a bad diode
  always_comb
  begin
    adc_word = adc_data_i;
    if (adc_chan_i == CH_CUR)
      adc_word = {adc_data_i[7:0], 2'b00}; // 8-bit current result sits in the high byte
    else if (adc_chan_i == CH_INT + 4'h1)
      adc_word = diode_bad[0] ? DIODE_FAULT_CODE : adc_data_i + trim_ofs(flt_en_reg[TRIM1_LSB +: 3]);
    else if (adc_chan_i == CH_INT + 4'h2)
      adc_word = diode_bad[1] ? DIODE_FAULT_CODE : adc_data_i + trim_ofs(int_low_reg[TRIM2_LSB +: 3]);
  end

  // the same words feed both read ports and the comparators
  tmf_result_mem #(
    .DEPTH(NUM_CH),
    .WIDTH(RES_W),
    .AW(4)
  ) u_mem (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .wr_en_i(adc_valid_i),
    .wr_addr_i(adc_chan_i),
    .wr_data_i(adc_word),
    .rd_addr_a_i(smb_addr_i[4:1]),
    .rd_data_a_o(mem_a),
    .rd_addr_b_i(jtag_addr_i[4:1]),
    .rd_data_b_o(mem_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-conversion capture; voltage pending bits restart after each scan end
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ov_pend_reg <= '0;
      uv_pend_reg <= '0;
      for (int i = 0; i < NUM_TEMP; i++)
      begin
        temp_reg[i] <= '0;
      end
    end
    else
    begin
      if (scan_done_i)
      begin
        ov_pend_reg <= '0;
        uv_pend_reg <= '0;
      end
      if (adc_valid_i && adc_chan_i < 4'(NUM_VOLT))
      begin
        // limits see only the high byte; the two low bits are dropped
        ov_pend_reg[adc_chan_i[2:0]] <= adc_data_i[9:2] > ov_lim_reg;
        uv_pend_reg[adc_chan_i[2:0]] <= adc_data_i[9:2] < uv_lim_reg;
      end
      else if (adc_valid_i && adc_chan_i >= CH_INT && adc_chan_i < CH_CUR)
      begin
        temp_reg[2'(adc_chan_i - CH_INT)] <= adc_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 10-bit signed threshold compares, primary and secondary per sensor
  generate
    for (genvar s = 0; s < NUM_TEMP; s++)
    begin : g_cmp
      if (s == 0)
      begin : g_int
        assign th_pri[s] = {th_reg[0], int_low_reg[INT_PRI_LSB +: 2]};
        assign th_sec[s] = {th_reg[1], int_low_reg[INT_SEC_LSB +: 2]};
      end
      else
      begin : g_rem
        assign th_pri[s] = {th_reg[2*s], 2'b00};
        assign th_sec[s] = {th_reg[2*s+1], 2'b00};
      end
      // signed half-degree codes, full width, gated by the sensor enable
      assign pri_hit[s] = flt_en_reg[FE_INT + s] & ($signed(temp_reg[s]) > $signed(th_pri[s]));
      assign sec_hit[s] = flt_en_reg[FE_INT + s] & ($signed(temp_reg[s]) > $signed(th_sec[s]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // current conditions, refreshed once per completed scan
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pri_now_reg <= 3'h0;
      sec_now_reg <= 3'h0;
      ov_now_reg <= 1'b0;
      uv_now_reg <= 1'b0;
    end
    else if (scan_done_i)
    begin
      pri_now_reg <= pri_hit;
      sec_now_reg <= sec_hit;
      ov_now_reg <= |ov_pend_reg;
      uv_now_reg <= |uv_pend_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags: a write with exactly one bit set clears that bit, set wins
  assign oc_now = flt_en_reg[FE_CS] & oc_sync;
  assign flag_set = {scan_done_i & (|uv_pend_reg), oc_now, scan_done_i & (|ov_pend_reg),
                     diode_bad[1] & flt_en_reg[FE_R2], diode_bad[0] & flt_en_reg[FE_R1],
                     scan_done_i ? pri_hit : 3'h0};
  assign flag_clr = (wr_en && wr_addr == OFS_FLAGS && $onehot(wr_data)) ? wr_data : 8'h00;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      flags_reg <= RST_ZERO;
      sec_flags_reg <= 3'h0;
    end
    else
    begin
      flags_reg <= (flags_reg & ~flag_clr) | flag_set;
      if (wr_en && wr_addr == OFS_SEC_FLAGS && $onehot(wr_data))
        sec_flags_reg <= (sec_flags_reg & ~wr_data[2:0]) | (scan_done_i ? sec_hit : 3'h0);
      else if (scan_done_i)
        sec_flags_reg <= sec_flags_reg | sec_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault pins follow present conditions; only overcurrent and diode-caused overtemp may latch
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      general_fault_out_a_n_o <= 1'b1;
      general_fault_out_b_n_o <= 1'b1;
      overtemp_out_n_o <= 1'b1;
      overcurrent_out_n_o <= 1'b1;
    end
    else
    begin
      general_fault_out_a_n_o <= ~gen_fault(fa_dep_reg, uv_now_reg, ov_now_reg, |sec_now_reg, oc_now);
      general_fault_out_b_n_o <= ~gen_fault(fb_dep_reg, uv_now_reg, ov_now_reg, |sec_now_reg, oc_now);
      // diode faults hold through the sticky flags until software clears them
      overtemp_out_n_o <= ~((ot_dep_reg[OTD_PRI] & (|pri_now_reg))
        | (ot_dep_reg[OTD_DIODE] & (flags_reg[FL_DIODE1] | flags_reg[FL_DIODE2])));
      overcurrent_out_n_o <= ~(oc_cfg_reg[OC_LATCH_BIT] ? (flt_en_reg[FE_CS] & flags_reg[FL_OC]) : oc_now);
    end
  end

  // alert trails the pins by one cycle since it is built from their flops
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      alert_n_o <= 1'b1;
    else
      alert_n_o <= ~(flt_en_reg[FE_ALERT] & (~general_fault_out_a_n_o | ~general_fault_out_b_n_o
        | ~overtemp_out_n_o | ~overcurrent_out_n_o | (|gpio_fault_i)));
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog settings decoded from the trim registers
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      oc_thresh_mv_o <= OC_MV_0;
      cs_gain_o <= CS_GAIN_0;
      remote1_gain_trim_o <= 6'h00;
      remote2_gain_trim_o <= 6'h00;
    end
    else
    begin
      case (cur_th_gain_reg[1:0])
        2'b00:
        begin
          oc_thresh_mv_o <= OC_MV_0;
          cs_gain_o <= CS_GAIN_0;
        end
        2'b01:
        begin
          oc_thresh_mv_o <= OC_MV_1;
          cs_gain_o <= CS_GAIN_1;
        end
        2'b10:
        begin
          oc_thresh_mv_o <= OC_MV_2;
          cs_gain_o <= CS_GAIN_2;
        end
        default:
        begin
          oc_thresh_mv_o <= OC_MV_3;
          cs_gain_o <= CS_GAIN_3;
        end
      endcase
      // register bit 6 is stored inverted
      remote1_gain_trim_o <= cur_th_gain_reg[7:GAIN1_LSB] ^ 6'(1 << (GAIN1_INV - GAIN1_LSB));
      remote2_gain_trim_o <= r2_gain_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reads: capture stage with the memory, then a registered data byte
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      smb_cfg_reg <= RST_ZERO;
      jtag_cfg_reg <= RST_ZERO;
      smb_res_reg <= 1'b0;
      jtag_res_reg <= 1'b0;
      smb_lsb_reg <= 1'b0;
      jtag_lsb_reg <= 1'b0;
      smb_rd_reg <= 1'b0;
      jtag_rd_reg <= 1'b0;
      smb_rdata_o <= RST_ZERO;
      jtag_rdata_o <= RST_ZERO;
      smb_rvalid_o <= 1'b0;
      jtag_rvalid_o <= 1'b0;
    end
    else
    begin
      smb_rd_reg <= smb_rd_i;
      jtag_rd_reg <= jtag_rd_i;
      smb_cfg_reg <= cfg_read(smb_addr_i);
      jtag_cfg_reg <= cfg_read(jtag_addr_i);
      smb_res_reg <= smb_addr_i <= OFS_RES_LAST;
      jtag_res_reg <= jtag_addr_i <= OFS_RES_LAST;
      smb_lsb_reg <= smb_addr_i[0];
      jtag_lsb_reg <= jtag_addr_i[0];
      smb_rvalid_o <= smb_rd_reg;
      jtag_rvalid_o <= jtag_rd_reg;
      if (smb_rd_reg)
        smb_rdata_o <= !smb_res_reg ? smb_cfg_reg : (smb_lsb_reg ? {6'h00, mem_a[1:0]} : mem_a[9:2]);
      if (jtag_rd_reg)
        jtag_rdata_o <= !jtag_res_reg ? jtag_cfg_reg : (jtag_lsb_reg ? {6'h00, mem_b[1:0]} : mem_b[9:2]);
    end
  end

endmodule

// [tb/tmf_temp_monitor_sva.sv]
// checker for the register ports, analog settings and fault pins
// assumes it is bound onto tmf_temp_monitor and gpio faults stay low
module tmf_sva
  import tmf_pkg::*;
(
  input wire logic clock_i, nrst_i, smb_rd_i, smb_wr_i, jtag_rd_i, smb_rvalid_o, jtag_rvalid_o, alert_n_o,
  input wire logic general_fault_out_a_n_o, general_fault_out_b_n_o, overtemp_out_n_o, overcurrent_out_n_o,
  input wire logic [7:0] smb_addr_i, smb_wdata_i, oc_thresh_mv_o,
  input wire logic [5:0] cs_gain_o, remote1_gain_trim_o, remote2_gain_trim_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  // all pins high means nothing may feed the alert
  wire logic pins_n = general_fault_out_a_n_o & general_fault_out_b_n_o & overtemp_out_n_o & overcurrent_out_n_o;
  wire logic gw = smb_wr_i && smb_addr_i == OFS_CUR_TH_GAIN;
  AST_SRV: assert property (smb_rd_i |-> ##2 smb_rvalid_o) else $error("serial read unanswered");
  AST_JRV: assert property (jtag_rd_i |-> ##2 jtag_rvalid_o) else $error("test read unanswered");
  AST_SRC: assert property (smb_rvalid_o |-> $past(smb_rd_i, 2)) else $error("answer without read");
  AST_OCP: assert property (int'(oc_thresh_mv_o) * int'(cs_gain_o) == 32'h4B0) else $error("gain pair");
  AST_OCS: assert property (gw && smb_wdata_i[1:0] == 2'b11 |-> ##2 oc_thresh_mv_o == OC_MV_3 &&
    cs_gain_o == CS_GAIN_3) else $error("select code 3");
  AST_GN1: assert property (gw |-> ##2 {remote1_gain_trim_o ^ 6'h10, 2'b00} ==
    ($past(smb_wdata_i, 2) & 8'hFC)) else $error("gain trim one");
  AST_GN2: assert property (smb_wr_i && smb_addr_i == OFS_R2_GAIN |-> ##2 {2'b00, remote2_gain_trim_o} ==
    ($past(smb_wdata_i, 2) & 8'h3F)) else $error("gain trim two");
  AST_ALR: assert property (!alert_n_o |-> !$past(pins_n)) else $error("alert without fault pin");
  cover property (smb_rvalid_o);
  cover property ($fell(overtemp_out_n_o));
  cover property ($rose(alert_n_o));
endmodule
bind tmf_temp_monitor tmf_sva chk (.*);

// [tb/tmf_host.sv]
// host model on the serial management port
// assumes read data lands two cycles after the read edge
module tmf_host
(
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr_o, wr_o, rd_o, wdata_o} = '0;
  // one-cycle write; flag clears carry one set bit
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
    @(posedge clock_i);
    wr_o <= 1'b0;
  endtask
  // read strobe, data taken after the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    {addr_o, rd_o} <= {a, 1'b1};
    @(posedge clock_i);
    rd_o <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1 d = rdata_i;
  endtask
endmodule

// [tb/test_tmf_temp_monitor.sv]
// self-checking bench for the temperature monitor
// assumes the host model on the serial port and the bound checker
module test_tmf_temp_monitor
  import tmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, nrst_i = 0, jtag_rd_i = 0, adc_valid_i = 0, scan_done_i = 0;
  logic smb_wr_i, smb_rd_i, smb_rvalid_o, jtag_rvalid_o, alert_n_o, fa_n, fb_n, ot_n, oc_n;
  logic [7:0] jtag_addr_i = 0, smb_addr_i, smb_wdata_i, smb_rdata_o, jtag_rdata_o, oc_thresh_mv_o;
  logic [9:0] adc_data_i = 0;
  logic [1:0] diode_open_i = 0, diode_short_i = 0;
  logic [5:0] cs_gain_o, g1, g2;
  logic [31:0] seed = 32'h962D3DEA;
  int error_cnt = 0, samples_checked = 0;
  tmf_temp_monitor uut (.clock_i, .nrst_i, .smb_addr_i, .smb_wr_i, .smb_rd_i, .smb_wdata_i, .smb_rdata_o,
    .smb_rvalid_o, .jtag_addr_i, .jtag_wr_i(1'b0), .jtag_rd_i, .jtag_wdata_i(8'h00), .jtag_rdata_o,
    .jtag_rvalid_o, .adc_valid_i, .adc_chan_i(4'h9), .adc_data_i, .scan_done_i, .diode_open_i,
    .diode_short_i, .oc_comp_i(1'b0), .gpio_fault_i(2'b00), .general_fault_out_a_n_o(fa_n),
    .general_fault_out_b_n_o(fb_n), .overtemp_out_n_o(ot_n), .overcurrent_out_n_o(oc_n), .alert_n_o,
    .oc_thresh_mv_o, .cs_gain_o, .remote1_gain_trim_o(g1), .remote2_gain_trim_o(g2));
  tmf_host h (.clock_i, .rdata_i(smb_rdata_o), .addr_o(smb_addr_i), .wr_o(smb_wr_i), .rd_o(smb_rd_i),
    .wdata_o(smb_wdata_i));
  initial forever #4 clock_i = ~clock_i;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // stored remote temperature: offset code times four added on
  function automatic logic [9:0] trimmed(logic [9:0] d, logic [2:0] t);
    return d + {{5{t[2]}}, t, 2'b00};
  endfunction
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    samples_checked++;
    error_cnt += int'(s !== e);
    if (s !== e) $display("FAIL %s expected %h seen %h", n, e, s);
  endtask
  task automatic rchk(string n, logic [7:0] a, logic [7:0] e);
    logic [7:0] d;
    h.rd(a, d);
    chk(n, d, e);
  endtask
  // one remote conversion then end of scan; pins and alert settle
  task automatic conv(logic [9:0] d);
    @(posedge clock_i) {adc_data_i, adc_valid_i} <= {d, 1'b1};
    @(posedge clock_i) {adc_valid_i, scan_done_i} <= 2'b01;
    @(posedge clock_i) scan_done_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    logic [7:0] v, th;
    logic [9:0] d, t;
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    rchk("otdep", 8'h1F, 8'h03);
    rchk("unmapped", 8'h60, 8'h00);
    h.wr(8'h4F, 8'hFF);
    rchk("r2gain", 8'h4F, 8'h3F);
    for (int c = 0; c < 4; c++)
    begin
      v = xs();
      v[1:0] = 2'(c);
      h.wr(8'h19, v);
      repeat (2) @(posedge clock_i);
      chk("ocsel", {oc_thresh_mv_o, cs_gain_o}, {8'hC8 >> v[1:0], 6'h06 << v[1:0]});
      chk("gain1", g1, v[7:2] ^ 6'h10);
    end
    // random temperatures; the first sits exactly on the threshold
    for (int i = 0; i < 8; i++)
    begin
      v = xs();
      th = xs();
      th[6] = th[7];
      t = 10'(xs());
      d = (i == 0) ? {th, 2'b00} - trimmed(10'h000, v[7:5]) : {t[8], t[8:0]};
      h.wr(8'h1B, {v[7:5], 5'h12});
      h.wr(8'h48, th);
      conv(d);
      t = trimmed(d, v[7:5]);
      chk("otpin", ot_n, !($signed(t) > $signed({th, 2'b00})));
      chk("alert", alert_n_o, ot_n);
      rchk("r1hi", 8'h12, t[9:2]);
      rchk("r1lo", 8'h13, {6'h00, t[1:0]});
      h.wr(8'h53, 8'h06);
      rchk("flagkept", 8'h53, {6'h00, !ot_n, 1'b0});
      h.wr(8'h53, 8'h02);
      rchk("flagclr", 8'h53, 8'h00);
    end
    @(posedge clock_i) {jtag_addr_i, jtag_rd_i} <= {8'h1B, 1'b1};
    @(posedge clock_i) jtag_rd_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1 chk("jtagrd", jtag_rdata_o, {v[7:5], 5'h12});
    h.wr(8'h48, 8'h7F);
    @(posedge clock_i) {diode_open_i, diode_short_i} <= 4'h9;
    repeat (3) @(posedge clock_i);
    conv(10'h0A0);
    rchk("dcode", 8'h12, 8'h00);
    rchk("dflag", 8'h53, 8'h08);
    @(posedge clock_i) {diode_open_i, diode_short_i} <= 4'h0;
    repeat (6) @(posedge clock_i);
    chk("otheld", {fa_n, fb_n, ot_n, oc_n}, 4'hD);
    h.wr(8'h53, 8'h08);
    repeat (3) @(posedge clock_i);
    chk("otfree", ot_n, 1'b1);
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    close_out();
  end
endmodule
